// [logic/lsps_pkg.sv]
// constants, field layout and decode helpers of the line-style pattern sequencer
// assumes a 32-bit classic wishbone register bus and one system clock
package lsps_pkg;
   localparam int LEN_W  = 16;
   localparam int FRAC_W = 4;
   localparam int STEP_W = LEN_W + FRAC_W;
   localparam int REM_W  = STEP_W + 1;
   localparam int DIAG_W = 8;
   localparam int ADR_W  = 8;

   localparam logic [ADR_W-1:0] ADR_DASH  = 8'h00;
   localparam logic [ADR_W-1:0] ADR_DOT   = 8'h04;
   localparam logic [ADR_W-1:0] ADR_SPACE = 8'h08;
   localparam logic [ADR_W-1:0] ADR_PHASE = 8'h0c;
   localparam logic [ADR_W-1:0] ADR_DIAG  = 8'h10;
   localparam logic [ADR_W-1:0] ADR_SCALE = 8'h14;
   localparam logic [ADR_W-1:0] ADR_YSTEP = 8'h18;

   localparam int PH_CNT_LSB = 0;
   localparam int PH_SEL_LSB = 16;
   localparam int SC_X_LSB   = 0;
   localparam int SC_Y_LSB   = 16;
   localparam int STYLE_BIT  = 12;
   localparam int EP_BIT     = 11;

   localparam logic [DIAG_W-1:0] DIAG_RST  = 8'h10;
   localparam logic [STEP_W-1:0] UNIT_STEP = 20'h00010;
   localparam logic [FRAC_W-1:0] FRAC_ZERO = 4'h0;

   localparam logic [1:0] SEL_SPC_DASH = 2'h0;
   localparam logic [1:0] SEL_DASH     = 2'h1;
   localparam logic [1:0] SEL_SPC_DOT  = 2'h2;
   localparam logic [1:0] SEL_DOT      = 2'h3;

   localparam logic [1:0] KIND_LINE   = 2'h0;
   localparam logic [1:0] KIND_ARC    = 2'h1;
   localparam logic [1:0] KIND_CIRCLE = 2'h2;

   localparam logic [1:0] MOVE_NONE = 2'h0;
   localparam logic [1:0] MOVE_X    = 2'h1;
   localparam logic [1:0] MOVE_Y    = 2'h2;
   localparam logic [1:0] MOVE_DIAG = 2'h3;

   function automatic logic [1:0] next_sel(input logic [1:0] s);
      unique case (s)
         SEL_SPC_DASH: next_sel = SEL_DASH;
         SEL_DASH:     next_sel = SEL_SPC_DOT;
         SEL_SPC_DOT:  next_sel = SEL_DOT;
         SEL_DOT:      next_sel = SEL_SPC_DASH;
      endcase
   endfunction

   function automatic logic is_space(input logic [1:0] s);
      is_space = (s == SEL_SPC_DASH) || (s == SEL_SPC_DOT);
   endfunction

   function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         bmerge[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
      end
   endfunction
endpackage

// [logic/lsps_ratio_div.sv]
// serial restoring divider: quot = (num << frac_w) / den, one bit a cycle
// assumes den is nonzero; start is ignored while a division runs
`timescale 1ns/10ps
module lsps_ratio_div #(
   parameter int W      = 16,
   parameter int FRAC_W = 4
) (
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic            start,
   input  wire logic [W-1:0]    num,
   input  wire logic [W-1:0]    den,
   output logic                 busy,
   output logic                 done,
   output logic [W+FRAC_W-1:0]  quot
);
   localparam int N_W = W + FRAC_W;
   typedef enum logic {DV_IDLE, DV_RUN} lsps_dv_t;
   typedef struct packed {
      lsps_dv_t          st;
      logic [N_W-1:0]    sh;
      logic [W:0]        rem;
      logic [W-1:0]      den;
      logic [5:0]        cnt;
      logic              done;
   } lsps_div_t;

   lsps_div_t st_ff;
   lsps_div_t nxt_st;
   logic [W:0] trial;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      trial = {st_ff.rem[W-1:0], st_ff.sh[N_W-1]};
      unique case (st_ff.st)
         DV_IDLE: begin
            if (start) begin
               nxt_st.st  = DV_RUN;
               nxt_st.sh  = {num, {FRAC_W{1'b0}}};
               nxt_st.rem = '0;
               nxt_st.den = den;
               nxt_st.cnt = 6'(N_W);
            end
         end
         DV_RUN: begin
            if (trial >= {1'b0, st_ff.den}) begin
               nxt_st.rem = trial - {1'b0, st_ff.den};
               nxt_st.sh  = {st_ff.sh[N_W-2:0], 1'b1};
            end else begin
               nxt_st.rem = trial;
               nxt_st.sh  = {st_ff.sh[N_W-2:0], 1'b0};
            end
            nxt_st.cnt = st_ff.cnt - 6'h01;
            if (st_ff.cnt == 6'h01) begin
               nxt_st.st   = DV_IDLE;
               nxt_st.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= '{st: DV_IDLE, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy = (st_ff.st == DV_RUN);
   assign done = st_ff.done;
   assign quot = st_ff.sh;
endmodule // lsps_ratio_div

// [logic/lsps_top.sv]
// line-style pattern sequencer: per-pixel write decision and style phase
// assumes a classic wishbone master and an interpolator giving one step per pixel
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module lsps_top
   import lsps_pkg::*;
(
   input  wire logic                      MCLK,
   input  wire logic                      RST_B,
   input  wire logic [lsps_pkg::ADR_W-1:0] WB_ADR_I,
   input  wire logic [31:0]               WB_DAT_I,
   output logic      [31:0]               WB_DAT_O,
   input  wire logic [3:0]                WB_SEL_I,
   input  wire logic                      WB_WE_I,
   input  wire logic                      WB_CYC_I,
   input  wire logic                      WB_STB_I,
   output logic                           WB_ACK_O,
   input  wire logic                      INSTR_START,
   input  wire logic [15:0]               INSTR_WORD,
   input  wire logic [1:0]                INSTR_KIND,
   input  wire logic                      INSTR_CURRENT,
   input  wire logic                      STEP_VALID,
   input  wire logic [1:0]                STEP_MOVE,
   input  wire logic                      STEP_FIRST,
   input  wire logic                      STEP_LAST,
   output logic                           SETUP_BUSY,
   output logic                           PIX_VALID,
   output logic                           PIX_WRITE
);
   import lsps_pkg::*;

   typedef struct packed {
      logic [LEN_W-1:0]  dash;
      logic [LEN_W-1:0]  dot;
      logic [LEN_W-1:0]  space;
      logic [1:0]        sel;
      logic [REM_W-1:0]  rem;
      logic [DIAG_W-1:0] diag;
      logic [LEN_W-1:0]  sx;
      logic [LEN_W-1:0]  sy;
      logic [STEP_W-1:0] ystep;
      logic              style;
      logic              ep;
      logic              cur;
      logic [1:0]        kind;
      logic              ack;
      logic [31:0]       rdat;
      logic              busy;
      logic              pvalid;
      logic              pwrite;
   } lsps_state_t;

   lsps_state_t st_ff;
   lsps_state_t nxt_st;

   logic              acc;
   logic              take;
   logic              div_start;
   logic              div_busy;
   logic              div_done;
   logic [STEP_W-1:0] div_quot;
   logic [STEP_W-1:0] dec;
   logic [REM_W-1:0]  sub;
   logic              wrap;
   logic [1:0]        nsel;
   logic [LEN_W-1:0]  nlen;
   logic              in_mark;
   logic              end_rule;
   logic [31:0]       wv;

   lsps_ratio_div #(
      .W      (LEN_W),
      .FRAC_W (FRAC_W)
   ) u_div (
      .clk   (MCLK),
      .rst_b (RST_B),
      .start (div_start),
      .num   (st_ff.sx),
      .den   (st_ff.sy),
      .busy  (div_busy),
      .done  (div_done),
      .quot  (div_quot)
   );

   always_comb begin
      nxt_st = st_ff;
      wv = '0;
      // classic single-cycle slave: ack one cycle after the strobe, then drop
      acc = WB_CYC_I && WB_STB_I && !st_ff.ack;
      nxt_st.ack = acc;

      // y step is worked out at line setup when scaling is in force
      div_start = INSTR_START && INSTR_WORD[STYLE_BIT] && (INSTR_KIND == KIND_LINE)
                  && (st_ff.sx != '0) && (st_ff.sy != '0);
      if (INSTR_START && INSTR_WORD[STYLE_BIT] && !div_start) begin
         nxt_st.ystep = UNIT_STEP;
      end
      if (div_done) begin
         nxt_st.ystep = div_quot;
      end
      nxt_st.busy = div_start || (div_busy && !div_done);

      // instruction bits latched; the phase itself is left alone
      if (INSTR_START) begin
         nxt_st.style = INSTR_WORD[STYLE_BIT];
         nxt_st.ep    = INSTR_WORD[EP_BIT];
         nxt_st.cur   = INSTR_CURRENT;
         nxt_st.kind  = INSTR_KIND;
      end

      take = STEP_VALID && !st_ff.busy;
      unique case (STEP_MOVE)
         MOVE_NONE: dec = '0;
         MOVE_X:    dec = UNIT_STEP;
         MOVE_Y:    dec = st_ff.ystep;
         MOVE_DIAG: dec = STEP_W'(st_ff.diag);
      endcase
      sub  = st_ff.rem - {1'b0, dec};
      wrap = sub[REM_W-1] || (sub == '0);
      nsel = next_sel(st_ff.sel);
      unique case (nsel)
         SEL_DASH:            nlen = st_ff.dash;
         SEL_DOT:             nlen = st_ff.dot;
         default:             nlen = st_ff.space;
      endcase

      // pixel judged on the phase in force before this step's decrement
      in_mark  = !is_space(st_ff.sel);
      end_rule = (st_ff.kind != KIND_CIRCLE);
      nxt_st.pvalid = take;
      nxt_st.pwrite = 1'b0;
      if (take) begin
         if (STEP_FIRST && end_rule && st_ff.cur) begin
            nxt_st.pwrite = 1'b0;
         end else if (STEP_FIRST && end_rule) begin
            nxt_st.pwrite = 1'b1;
         end else if (!st_ff.style) begin
            nxt_st.pwrite = 1'b1;
         end else if (STEP_LAST && end_rule) begin
            nxt_st.pwrite = st_ff.ep || in_mark;
         end else begin
            nxt_st.pwrite = in_mark;
         end
         if (st_ff.style && STEP_MOVE != MOVE_NONE) begin
            if (wrap) begin
               nxt_st.sel = nsel;
               nxt_st.rem = sub + {1'b0, nlen, FRAC_ZERO};
            end else begin
               nxt_st.rem = sub;
            end
         end
      end

      // register writes; a phase write overrides a same-cycle step
      if (acc && WB_WE_I) begin
         unique case (WB_ADR_I)
            ADR_DASH: begin
               wv = bmerge(32'(st_ff.dash), WB_DAT_I, WB_SEL_I);
               nxt_st.dash = wv[LEN_W-1:0];
            end
            ADR_DOT: begin
               wv = bmerge(32'(st_ff.dot), WB_DAT_I, WB_SEL_I);
               nxt_st.dot = wv[LEN_W-1:0];
            end
            ADR_SPACE: begin
               wv = bmerge(32'(st_ff.space), WB_DAT_I, WB_SEL_I);
               nxt_st.space = wv[LEN_W-1:0];
            end
            ADR_PHASE: begin
               wv = bmerge({14'h0000, st_ff.sel, st_ff.rem[FRAC_W +: LEN_W]},
                           WB_DAT_I, WB_SEL_I);
               nxt_st.sel = wv[PH_SEL_LSB +: 2];
               nxt_st.rem = {1'b0, wv[PH_CNT_LSB +: LEN_W], FRAC_ZERO};
            end
            ADR_DIAG: begin
               wv = bmerge(32'(st_ff.diag), WB_DAT_I, WB_SEL_I);
               nxt_st.diag = wv[DIAG_W-1:0];
            end
            ADR_SCALE: begin
               wv = bmerge({st_ff.sy, st_ff.sx}, WB_DAT_I, WB_SEL_I);
               nxt_st.sx = wv[SC_X_LSB +: LEN_W];
               nxt_st.sy = wv[SC_Y_LSB +: LEN_W];
            end
            default: begin
               wv = '0;
            end
         endcase
      end

      nxt_st.rdat = '0;
      if (acc && !WB_WE_I) begin
         unique case (WB_ADR_I)
            ADR_DASH:  nxt_st.rdat = 32'(st_ff.dash);
            ADR_DOT:   nxt_st.rdat = 32'(st_ff.dot);
            ADR_SPACE: nxt_st.rdat = 32'(st_ff.space);
            ADR_PHASE: nxt_st.rdat = {14'h0000, st_ff.sel, st_ff.rem[FRAC_W +: LEN_W]};
            ADR_DIAG:  nxt_st.rdat = 32'(st_ff.diag);
            ADR_SCALE: nxt_st.rdat = {st_ff.sy, st_ff.sx};
            ADR_YSTEP: nxt_st.rdat = 32'(st_ff.ystep);
            default:   nxt_st.rdat = '0;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         st_ff <= '{diag: DIAG_RST, ystep: UNIT_STEP, default: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign WB_DAT_O   = st_ff.rdat;
   assign WB_ACK_O   = st_ff.ack;
   assign SETUP_BUSY = st_ff.busy;
   assign PIX_VALID  = st_ff.pvalid;
   assign PIX_WRITE  = st_ff.pwrite;

   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   sequence s_setup_start;
      div_start;
   endsequence
   sequence s_setup_run;
      SETUP_BUSY [*8];
   endsequence

   AST_YSTEP_SETUP: assert property (s_setup_start |=> s_setup_run ##[1:20] !SETUP_BUSY)
      else $error("line setup did not finish in time");
   AST_SOLID_WRITE: assert property (take && !st_ff.style && !STEP_FIRST |=> PIX_WRITE)
      else $error("solid pixel not written");
   AST_SPACE_SUPPRESS: assert property (take && st_ff.style && is_space(st_ff.sel)
      && !STEP_FIRST && !STEP_LAST |=> PIX_VALID && !PIX_WRITE)
      else $error("write inside a space element");
   AST_AXIS_DEC: assert property (take && st_ff.style && STEP_MOVE == MOVE_X && !wrap
      && !acc |=> st_ff.rem == $past(st_ff.rem) - REM_W'(UNIT_STEP))
      else $error("axis step did not subtract one");
   AST_DIAG_DEC: assert property (take && st_ff.style && STEP_MOVE == MOVE_DIAG && !wrap
      && !acc |=> st_ff.rem == $past(st_ff.rem) - REM_W'($past(st_ff.diag)))
      else $error("diagonal step did not subtract diagonal length");
   AST_FIRST_PLAIN: assert property (take && STEP_FIRST && st_ff.kind != KIND_CIRCLE
      && !st_ff.cur |=> PIX_WRITE)
      else $error("first point of plain draw not written");
   AST_FIRST_CUR: assert property (take && STEP_FIRST && st_ff.kind != KIND_CIRCLE
      && st_ff.cur |=> !PIX_WRITE)
      else $error("first point of current draw written");
   AST_LAST_FORCE: assert property (take && STEP_LAST && !STEP_FIRST && st_ff.ep
      && st_ff.kind != KIND_CIRCLE |=> PIX_WRITE)
      else $error("forced last point not written");
   AST_PHASE_KEEP: assert property (INSTR_START && !STEP_VALID && !acc
      |=> $stable(st_ff.sel) && $stable(st_ff.rem))
      else $error("phase changed at instruction start");
   AST_PHASE_LOAD: assert property (acc && WB_WE_I && WB_ADR_I == ADR_PHASE
      && WB_SEL_I[2] |=> st_ff.sel == $past(WB_DAT_I[PH_SEL_LSB +: 2]))
      else $error("phase write did not load selector");
   AST_WRAP: assert property (take && st_ff.style && STEP_MOVE != MOVE_NONE && wrap
      && !acc |=> st_ff.sel == next_sel($past(st_ff.sel)))
      else $error("element did not advance at zero");

   // bus and step handshakes
   sequence s_ack_give;
      WB_ACK_O;
   endsequence
   sequence s_ack_drop;
      !WB_ACK_O;
   endsequence

   AST_ACK_PULSE: assert property (acc |=> s_ack_give ##1 s_ack_drop)
      else $error("bus ack was not a single pulse");
   AST_READ_ZERO: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
      else $error("read data shown without ack");
   AST_STEP_ANSWER: assert property (take |=> PIX_VALID)
      else $error("accepted step not answered");
   AST_STEP_IDLE: assert property (!take |=> !PIX_VALID)
      else $error("pixel answer without an accepted step");
   AST_STEP_REFUSED: assert property (STEP_VALID && SETUP_BUSY |=> !PIX_VALID)
      else $error("step answered during line setup");
   AST_SETUP_BUSY_START: assert property (div_start |=> SETUP_BUSY)
      else $error("line setup did not raise busy");

   // style and end-point decisions
   AST_STYLE_LATCH: assert property (INSTR_START
      |=> st_ff.style == $past(INSTR_WORD[STYLE_BIT]))
      else $error("style bit not taken at instruction start");
   AST_SOLID_NO_STEP: assert property (take && !st_ff.style && !acc
      |=> $stable(st_ff.sel) && $stable(st_ff.rem))
      else $error("solid draw moved the phase");
   AST_MARK_WRITE: assert property (take && st_ff.style && !is_space(st_ff.sel)
      && !STEP_FIRST |=> PIX_WRITE)
      else $error("pixel inside dash or dot not written");
   AST_LAST_COND: assert property (take && st_ff.style && STEP_LAST && !STEP_FIRST
      && !st_ff.ep && is_space(st_ff.sel) && st_ff.kind != KIND_CIRCLE |=> !PIX_WRITE)
      else $error("unforced last point written inside a space");

   // phase stepping and reloading, leftover carried into the new element
   AST_Y_DEC: assert property (take && st_ff.style && STEP_MOVE == MOVE_Y && !wrap
      && !acc |=> st_ff.rem == $past(st_ff.rem) - REM_W'($past(st_ff.ystep)))
      else $error("y step did not subtract the y step length");
   AST_NO_MOVE: assert property (take && STEP_MOVE == MOVE_NONE && !acc
      |=> $stable(st_ff.sel) && $stable(st_ff.rem))
      else $error("phase moved on a step without movement");
   AST_LOAD_DASH: assert property (take && st_ff.style && wrap && !acc
      && STEP_MOVE == MOVE_X && st_ff.sel == SEL_SPC_DASH
      |=> st_ff.rem == $past(st_ff.rem) - REM_W'(UNIT_STEP)
      + REM_W'({$past(st_ff.dash), FRAC_ZERO}))
      else $error("dash length not loaded with leftover");
   AST_LOAD_DOT: assert property (take && st_ff.style && wrap && !acc
      && STEP_MOVE == MOVE_X && st_ff.sel == SEL_SPC_DOT
      |=> st_ff.rem == $past(st_ff.rem) - REM_W'(UNIT_STEP)
      + REM_W'({$past(st_ff.dot), FRAC_ZERO}))
      else $error("dot length not loaded with leftover");

   // register loads
   AST_PHASE_COUNT: assert property (acc && WB_WE_I && WB_ADR_I == ADR_PHASE
      && WB_SEL_I[1:0] == 2'h3
      |=> st_ff.rem == {1'b0, $past(WB_DAT_I[PH_CNT_LSB +: LEN_W]), FRAC_ZERO})
      else $error("phase write did not load the count");
   AST_DIAG_LOAD: assert property (acc && WB_WE_I && WB_ADR_I == ADR_DIAG
      && WB_SEL_I[0] |=> st_ff.diag == $past(WB_DAT_I[DIAG_W-1:0]))
      else $error("diagonal length not loaded");
   AST_UNIT_YSTEP: assert property (INSTR_START && !div_start
      && INSTR_WORD[STYLE_BIT] && !div_done |=> st_ff.ystep == UNIT_STEP)
      else $error("y step not unity outside scaled line setup");
endmodule // lsps_top

// [testbench/lsps_interp_model.sv]
// interpolator model: issues one drawing instruction and its pixel steps
// assumes the sequencer answers each accepted step one cycle later
`timescale 1ns/10ps
module lsps_interp_model (
   input  wire logic        clk,
   input  wire logic        setup_busy,
   input  wire logic        pix_valid,
   input  wire logic        pix_write,
   output logic             instr_start,
   output logic [15:0]      instr_word,
   output logic [1:0]       instr_kind,
   output logic             instr_current,
   output logic             step_valid,
   output logic [1:0]       step_move,
   output logic             step_first,
   output logic             step_last
);
   logic [15:0] wr_bits;
   int          idx;
   int          busy_cnt;

   initial begin
      {instr_start, instr_word, instr_kind, instr_current} = '0;
      {step_valid, step_move, step_first, step_last} = '0;
      wr_bits = '0;
      idx = 0;
      busy_cnt = 0;
   end

   // one bit per answered pixel, first pixel in bit 0
   always @(posedge clk) begin
      if (pix_valid === 1'b1) begin
         wr_bits[idx] <= pix_write;
         idx <= idx + 1;
      end
   end

   task automatic run(input logic [15:0] w, input logic [1:0] k, input logic c,
                      input int n, input logic [1:0] mv);
      wr_bits = '0;
      idx = 0;
      @(posedge clk);
      instr_start <= 1'b1;
      instr_word <= w;
      instr_kind <= k;
      instr_current <= c;
      @(posedge clk);
      instr_start <= 1'b0;
      // a step offered during setup must be dropped; setup length is counted
      busy_cnt = 0;
      @(negedge clk);
      while (setup_busy !== 1'b0) begin
         busy_cnt++;
         @(posedge clk);
         step_valid <= (busy_cnt == 2);
         @(negedge clk);
      end
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         step_valid <= 1'b1;
         step_move <= mv;
         step_first <= (i == 0);
         step_last <= (i == n - 1);
      end
      @(posedge clk);
      {step_valid, step_first, step_last} <= '0;
      while (idx != n) @(posedge clk);
   endtask
endmodule // lsps_interp_model

// [testbench/tb_top.sv]
// self-checking bench of the line-style pattern sequencer
// assumes lsps_top with a classic wishbone slave and the interpolator model
`timescale 1ns/10ps
module tb_top;
   import lsps_pkg::*;
   logic        MCLK = 1'b0, RST_B = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = '0;
   logic [31:0] dat = '0, dat_o, q;
   logic [3:0]  sel = 4'hf;
   logic        ack, i_start, i_cur, s_valid, s_first, s_last, busy, p_valid, p_write;
   logic [15:0] i_word;
   logic [1:0]  i_kind, s_move;
   int          miscompares = 0, tests_run = 0, cycles = 0;

   always #2.5 MCLK = ~MCLK;

   lsps_top lsps_top_i (.MCLK(MCLK), .RST_B(RST_B), .WB_ADR_I(adr), .WB_DAT_I(dat),
      .WB_DAT_O(dat_o), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_ACK_O(ack), .INSTR_START(i_start), .INSTR_WORD(i_word), .INSTR_KIND(i_kind),
      .INSTR_CURRENT(i_cur), .STEP_VALID(s_valid), .STEP_MOVE(s_move),
      .STEP_FIRST(s_first), .STEP_LAST(s_last), .SETUP_BUSY(busy),
      .PIX_VALID(p_valid), .PIX_WRITE(p_write));

   lsps_interp_model lsps_interp_model_i (.clk(MCLK), .setup_busy(busy),
      .pix_valid(p_valid), .pix_write(p_write), .instr_start(i_start),
      .instr_word(i_word), .instr_kind(i_kind), .instr_current(i_cur),
      .step_valid(s_valid), .step_move(s_move), .step_first(s_first),
      .step_last(s_last));

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wb_sel(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
      @(posedge MCLK);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do @(posedge MCLK); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_sel(w, a, d, 4'hf);
   endtask

   task automatic lengths(input logic [15:0] da, input logic [15:0] dt, input logic [15:0] sp);
      wb(1'b1, ADR_DASH, {16'h0, da});
      wb(1'b1, ADR_DOT, {16'h0, dt});
      wb(1'b1, ADR_SPACE, {16'h0, sp});
   endtask

   task automatic draw_chk(input string name, input logic [15:0] w, input logic [1:0] k,
                           input logic c, input int n, input logic [1:0] mv,
                           input logic [15:0] exp);
      lsps_interp_model_i.run(w, k, c, n, mv);
      chk(name, {16'h0, exp}, {16'h0, lsps_interp_model_i.wr_bits});
   endtask

   task automatic t_reset_values();
      wb(1'b0, ADR_DIAG, '0);
      chk("diag reset", 32'h00000010, q);
      wb(1'b0, ADR_PHASE, '0);
      chk("phase reset", 32'h00000000, q);
      wb(1'b0, ADR_YSTEP, '0);
      chk("ystep reset", {12'h0, UNIT_STEP}, q);
      wb(1'b0, 8'h40, '0);
      chk("unmapped read", 32'h00000000, q);
   endtask

   task automatic t_pattern_axis();
      lengths(16'h0003, 16'h0002, 16'h0002);
      wb(1'b1, ADR_PHASE, {14'h0, SEL_SPC_DASH, 16'h0001});
      draw_chk("axis pattern", 16'h1000, KIND_LINE, 1'b0, 11, MOVE_X, 16'h04cf);
      wb(1'b0, ADR_PHASE, '0);
      chk("phase after draw", {14'h0, SEL_DASH, 16'h0002}, q);
      draw_chk("solid", 16'h0000, KIND_LINE, 1'b0, 5, MOVE_X, 16'h001f);
      wb(1'b0, ADR_PHASE, '0);
      chk("phase kept by solid", {14'h0, SEL_DASH, 16'h0002}, q);
   endtask

   task automatic t_end_points();
      // continues from dash with two left: first hidden, last forced
      draw_chk("current ep1", 16'h1800, KIND_LINE, 1'b1, 3, MOVE_X, 16'h0006);
      wb(1'b1, ADR_PHASE, {14'h0, SEL_SPC_DOT, 16'h0003});
      draw_chk("plain ep0", 16'h1000, KIND_ARC, 1'b0, 2, MOVE_Y, 16'h0001);
      wb(1'b1, ADR_PHASE, {14'h0, SEL_DOT, 16'h0001});
      draw_chk("circle", 16'h1800, KIND_CIRCLE, 1'b0, 2, MOVE_X, 16'h0001);
   endtask

   task automatic t_diagonal();
      wb(1'b1, ADR_DIAG, 32'h00000028);
      wb(1'b0, ADR_DIAG, '0);
      chk("diag readback", 32'h00000028, q);
      lengths(16'h0003, 16'h0003, 16'h0003);
      wb(1'b1, ADR_PHASE, {14'h0, SEL_DASH, 16'h0003});
      draw_chk("diag leftover", 16'h1000, KIND_LINE, 1'b0, 6, MOVE_DIAG, 16'h002b);
   endtask

   task automatic t_scaling();
      wb(1'b1, ADR_SCALE, 32'h00010002);
      lengths(16'h0004, 16'h0004, 16'h0004);
      wb(1'b1, ADR_PHASE, {14'h0, SEL_DASH, 16'h0004});
      draw_chk("scaled y", 16'h1000, KIND_LINE, 1'b0, 5, MOVE_Y, 16'h0013);
      chk("setup busy cycles", STEP_W + 1, lsps_interp_model_i.busy_cnt);
      wb(1'b0, ADR_YSTEP, '0);
      chk("ystep ratio", 32'h00000020, q);
   endtask

   task automatic t_lanes_and_hold();
      wb_sel(1'b1, ADR_DASH, 32'h000012aa, 4'h1);
      wb(1'b0, ADR_DASH, '0);
      chk("dash byte lane", 32'h000000aa, q);
      wb(1'b1, 8'h44, 32'hffffffff);
      wb(1'b1, ADR_YSTEP, 32'h00000000);
      wb(1'b0, ADR_DIAG, '0);
      chk("diag after stray writes", 32'h00000028, q);
      wb(1'b0, ADR_YSTEP, '0);
      chk("ystep read only", 32'h00000020, q);
      wb(1'b1, ADR_PHASE, {14'h0, SEL_DASH, 16'h0002});
      draw_chk("no move", 16'h1000, KIND_ARC, 1'b0, 2, MOVE_NONE, 16'h0003);
      chk("no setup for arc", 32'h00000000, lsps_interp_model_i.busy_cnt);
      wb(1'b0, ADR_PHASE, '0);
      chk("phase kept without move", {14'h0, SEL_DASH, 16'h0002}, q);
   endtask

   initial begin
      repeat (6) @(posedge MCLK);
      RST_B <= 1'b1;
      t_reset_values();
      t_pattern_axis();
      t_end_points();
      t_diagonal();
      t_scaling();
      t_lanes_and_hold();
      tally_and_finish();
   end
endmodule // tb_top
